/* File: logic/rss_pkg.sv */
// Constants shared by the reset source sequencer and its helpers.
// Assumes a single 50 MHz system clock and an 8-bit special function register port.
package rss_pkg;

  // Special function register addresses
  localparam logic [7:0] RSS_LVD_ADDR   = 8'hE7;
  localparam logic [7:0] RSS_SWRST_ADDR = 8'hF7;
  localparam logic [7:0] RSS_WDOG_ADDR  = 8'hFF;
  localparam logic [7:0] RSS_REG_RESET  = 8'h00;
  localparam logic [7:0] RSS_RD_ZERO    = 8'h00;

  // Field positions
  localparam int RSS_SWRST_TRIG_BIT = 0;
  localparam int RSS_WDOG_EN_BIT    = 7;

  // Clock and time figures
  localparam longint RSS_CLK_HZ     = 64'd50_000_000;
  localparam longint RSS_POR_DIP_MS = 64'd200;
  localparam longint RSS_POR_DIP_CYC = (RSS_CLK_HZ * RSS_POR_DIP_MS + 64'd999) / 64'd1000;
  localparam int     RSS_LONG_EXP   = 17;
  localparam int     RSS_SHORT_EXP  = 15;
  localparam int     RSS_LONG_CYC   = 1 << RSS_LONG_EXP;
  localparam int     RSS_SHORT_CYC  = 1 << RSS_SHORT_EXP;

  // Positions of the asynchronous inputs in the synchroniser bundle
  localparam int RSS_SYNC_W     = 6;
  localparam int RSS_IX_EXT     = 0;
  localparam int RSS_IX_LOW1V   = 1;
  localparam int RSS_IX_ABOVE2V = 2;
  localparam int RSS_IX_DIP     = 3;
  localparam int RSS_IX_ALVD    = 4;
  localparam int RSS_IX_DLVD    = 5;

  typedef enum logic [2:0] {
    RSS_ST_RUN   = 3'b001,
    RSS_ST_HOLD  = 3'b010,
    RSS_ST_COUNT = 3'b100
  } rss_state_e;

endpackage : rss_pkg

/* File: logic/rss_sequencer.sv */
// Reset source sequencer: gathers reset sources, stretches the reset,
// drives the pin pull-up and oscillator halt, and flags low supplies.
// Assumes analog comparators deliver asynchronous levels and the
// configuration straps and watchdog timeout are on the mclk domain.
`timescale 1ns/1ps
`default_nettype none

module rss_sequencer
  import rss_pkg::*;
#(
  parameter int     LONG_CYC    = rss_pkg::RSS_LONG_CYC,
  parameter int     SHORT_CYC   = rss_pkg::RSS_SHORT_CYC,
  parameter longint POR_DIP_CYC = rss_pkg::RSS_POR_DIP_CYC
) (
  // Clock, reset, enable
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  // Special function register port
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata_q,
  // Reset pin and supply comparators (asynchronous)
  input  wire logic       ext_rst_pin,
  input  wire logic       digital_supply_below_1v,
  input  wire logic       digital_supply_above_2v,
  input  wire logic       supply_dip_below,
  input  wire logic       analog_supply_low,
  input  wire logic       digital_supply_low,
  // Configuration and watchdog (mclk domain)
  input  wire logic       hw_config_first_wdog_en,
  input  wire logic       hw_config_second_dip_en,
  input  wire logic       wdog_timeout,
  // Reset and supply outputs
  output logic            sys_rst_q,
  output logic            pins_pull_high_q,
  output logic            osc_halt_q,
  output logic            lvd_irq_analog_q,
  output logic            lvd_irq_digital_q,
  output logic      [7:0] low_voltage_detect_control_q
);
  import rss_pkg::*;

  localparam int CNT_W = $clog2(LONG_CYC > SHORT_CYC ? LONG_CYC : SHORT_CYC) + 1;
  localparam int DIP_W = $clog2(POR_DIP_CYC + 1) + 1;
  localparam logic [CNT_W-1:0] LONG_LOAD  = CNT_W'(LONG_CYC - 1);
  localparam logic [CNT_W-1:0] SHORT_LOAD = CNT_W'(SHORT_CYC - 1);
  localparam logic [DIP_W-1:0] DIP_LIMIT  = DIP_W'(POR_DIP_CYC);

  function automatic logic sfr_hit(input logic [7:0] addr, input logic [7:0] target);
    sfr_hit = (addr == target);
  endfunction : sfr_hit

  // Registers
  logic [7:0]       software_reset_control_q;
  logic [7:0]       watchdog_control_q;
  rss_state_e       state_q;
  rss_state_e       state_d;
  logic             por_arm_q;
  logic [DIP_W-1:0] dip_cnt_q;
  logic             len_short_q;
  logic             ext_prev_q;
  logic             por_prev_q;
  logic             dip_prev_q;
  logic             alvd_prev_q;
  logic             dlvd_prev_q;

  // Synchronised levels
  logic [RSS_SYNC_W-1:0] async_bus;
  logic [RSS_SYNC_W-1:0] syn;

  always_comb begin
    async_bus                 = '0;
    async_bus[RSS_IX_EXT]     = ext_rst_pin;
    async_bus[RSS_IX_LOW1V]   = digital_supply_below_1v;
    async_bus[RSS_IX_ABOVE2V] = digital_supply_above_2v;
    async_bus[RSS_IX_DIP]     = supply_dip_below;
    async_bus[RSS_IX_ALVD]    = analog_supply_low;
    async_bus[RSS_IX_DLVD]    = digital_supply_low;
  end

  rss_sync3 #(
    .W (RSS_SYNC_W)
  ) u_sync (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .ce       (ce),
    .async_in (async_bus),
    .level_q  (syn)
  );

  // Decoding
  wire wr_lvd   = sfr_wr & sfr_hit(sfr_addr, RSS_LVD_ADDR);
  wire wr_swrst = sfr_wr & sfr_hit(sfr_addr, RSS_SWRST_ADDR);
  wire wr_wdog  = sfr_wr & sfr_hit(sfr_addr, RSS_WDOG_ADDR);
  wire rd_lvd   = sfr_hit(sfr_addr, RSS_LVD_ADDR);
  wire rd_swrst = sfr_hit(sfr_addr, RSS_SWRST_ADDR);
  wire rd_wdog  = sfr_hit(sfr_addr, RSS_WDOG_ADDR);
  // Undefined addresses read as zero
  wire [7:0] rd_mux = rd_lvd   ? low_voltage_detect_control_q :
                      rd_swrst ? software_reset_control_q :
                      rd_wdog  ? watchdog_control_q : RSS_RD_ZERO;

  // Reset sources
  wire ext_hi  = syn[RSS_IX_EXT];
  wire dip_en  = hw_config_second_dip_en;
  wire sw_trig = wr_swrst & sfr_wdata[RSS_SWRST_TRIG_BIT];
  wire wd_trig = wdog_timeout & hw_config_first_wdog_en & watchdog_control_q[RSS_WDOG_EN_BIT];
  wire por_hold = por_arm_q & ~dip_en;
  wire dip_hold = dip_en & syn[RSS_IX_DIP];
  wire hold_any = ext_hi | por_hold | dip_hold;
  wire pulse_trig = sw_trig | wd_trig;
  wire dip_long = (dip_cnt_q >= DIP_LIMIT);

  wire new_long  = (ext_hi & ~ext_prev_q) | (por_hold & ~por_prev_q) | pulse_trig;
  wire new_short = dip_hold & ~dip_prev_q;
  wire short_sel = new_long ? 1'b0 : (new_short ? 1'b1 : len_short_q);

  logic             cnt_load;
  logic [CNT_W-1:0] cnt_val;
  logic             cnt_done;

  always_comb begin
    state_d  = state_q;
    cnt_load = 1'b0;
    case (state_q)
      RSS_ST_RUN: begin
        if (hold_any) begin
          state_d = RSS_ST_HOLD;
        end else if (pulse_trig) begin
          state_d  = RSS_ST_COUNT;
          cnt_load = 1'b1;
        end
      end
      RSS_ST_HOLD: begin
        if (!hold_any) begin
          state_d  = RSS_ST_COUNT;
          cnt_load = 1'b1;
        end
      end
      RSS_ST_COUNT: begin
        if (hold_any) begin
          state_d = RSS_ST_HOLD;
        end else if (pulse_trig) begin
          cnt_load = 1'b1;
        end else if (cnt_done) begin
          state_d = RSS_ST_RUN;
        end
      end
      default: begin
        state_d = RSS_ST_HOLD;
      end
    endcase
  end

  assign cnt_val = short_sel ? SHORT_LOAD : LONG_LOAD;

  rss_stretch #(
    .W (CNT_W)
  ) u_stretch (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .ce       (ce),
    .load     (cnt_load),
    .load_val (cnt_val),
    .done     (cnt_done)
  );

  // Sequencer state; rst_n stands for power arriving
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_q     <= RSS_ST_HOLD;
      len_short_q <= 1'b0;
      ext_prev_q  <= 1'b0;
      por_prev_q  <= 1'b1;
      dip_prev_q  <= 1'b0;
    end else if (ce) begin
      state_q     <= state_d;
      len_short_q <= short_sel;
      ext_prev_q  <= ext_hi;
      por_prev_q  <= por_hold;
      dip_prev_q  <= dip_hold;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      por_arm_q <= 1'b1;
      dip_cnt_q <= '0;
    end else if (ce) begin
      if (!syn[RSS_IX_LOW1V]) begin
        dip_cnt_q <= '0;
      end else if (!dip_long) begin
        dip_cnt_q <= dip_cnt_q + 1'b1;
      end
      // Rearm wins over release; short dips never rearm
      if (dip_long) begin
        por_arm_q <= 1'b1;
      end else if (syn[RSS_IX_ABOVE2V]) begin
        por_arm_q <= 1'b0;
      end
    end
  end

  // Registers and read data
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      low_voltage_detect_control_q <= RSS_REG_RESET;
      software_reset_control_q     <= RSS_REG_RESET;
      watchdog_control_q           <= RSS_REG_RESET;
      sfr_rdata_q                  <= RSS_RD_ZERO;
    end else if (ce) begin
      if (wr_lvd) begin
        low_voltage_detect_control_q <= sfr_wdata;
      end
      if (wr_swrst) begin
        software_reset_control_q <= sfr_wdata;
      end else if (state_q == RSS_ST_COUNT && state_d == RSS_ST_RUN) begin
        // Trigger bit self-clears when the reset completes
        software_reset_control_q <= RSS_REG_RESET;
      end
      if (wr_wdog) begin
        watchdog_control_q <= sfr_wdata;
      end
      if (sfr_rd) begin
        sfr_rdata_q <= rd_mux;
      end
    end
  end

  // Reset and pull-up outputs follow the next state so pins track reset exactly
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sys_rst_q         <= 1'b1;
      pins_pull_high_q  <= 1'b1;
      osc_halt_q        <= 1'b0;
      lvd_irq_analog_q  <= 1'b0;
      lvd_irq_digital_q <= 1'b0;
      alvd_prev_q       <= 1'b0;
      dlvd_prev_q       <= 1'b0;
    end else if (ce) begin
      sys_rst_q         <= (state_d != RSS_ST_RUN);
      pins_pull_high_q  <= (state_d != RSS_ST_RUN);
      osc_halt_q        <= ext_hi;
      alvd_prev_q       <= syn[RSS_IX_ALVD];
      dlvd_prev_q       <= syn[RSS_IX_DLVD];
      lvd_irq_analog_q  <= syn[RSS_IX_ALVD] & ~alvd_prev_q;
      lvd_irq_digital_q <= syn[RSS_IX_DLVD] & ~dlvd_prev_q;
    end
  end
endmodule : rss_sequencer
`default_nettype wire

/* File: logic/rss_stretch.sv */
// Down counter that stretches a reset for a loaded number of cycles.
// Assumes the owner loads length minus one and watches the done flag.
`timescale 1ns/1ps
`default_nettype none
module rss_stretch #(
  parameter int W = 18
) (
  // Clock, reset, enable
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  // Control
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic              done
);
  logic [W-1:0] cnt_q;

  assign done = (cnt_q == '0);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (ce) begin
      if (load) begin
        cnt_q <= load_val;
      end else if (!done) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule : rss_stretch
`default_nettype wire

/* File: logic/rss_sync3.sv */
// Three-stage synchroniser for a bundle of asynchronous levels.
// Assumes inputs come from pins or analog comparators outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module rss_sync3 #(
  parameter int W = 1
) (
  // Clock, reset, enable
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  // Levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] level_q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      // Accept a change only once stages two and three agree
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          s1_q[i]    <= 1'b0;
          s2_q[i]    <= 1'b0;
          s3_q[i]    <= 1'b0;
          level_q[i] <= 1'b0;
        end else if (ce) begin
          s1_q[i] <= async_in[i];
          s2_q[i] <= s1_q[i];
          s3_q[i] <= s2_q[i];
          if (s2_q[i] == s3_q[i]) begin
            level_q[i] <= s3_q[i];
          end
        end
      end
    end
  endgenerate
endmodule : rss_sync3
`default_nettype wire

/* File: tb/rss_rails.sv */
// Model of the reset pin circuit and the supply comparator levels.
// Assumes the bench calls its tasks from one process; levels move at clock edges.
`timescale 1ns/1ps
`default_nettype none
module rss_rails (
  // Clock
  input wire logic                       mclk,
  // Pin and comparator levels
  output logic [rss_pkg::RSS_SYNC_W-1:0] lvl
);
  import rss_pkg::*;
  initial lvl = 6'h00;
  task automatic flip(input logic [5:0] m);
    @(posedge mclk);
    lvl <= lvl ^ m;
  endtask : flip
  // Masked levels inverted for n periods, then restored
  task automatic pulse(input logic [5:0] m, input int n);
    flip(m);
    repeat (n) @(posedge mclk);
    lvl <= lvl ^ m;
  endtask : pulse
endmodule : rss_rails
`default_nettype wire

/* File: tb/rss_seq_properties.sv */
// Port-level checks for the reset source sequencer.
// Assumes it is bound to rss_sequencer and that ce stays high in the bench.
`timescale 1ns/1ps
`default_nettype none
module rss_seq_properties #(
  parameter int     LONG_CYC    = 16,
  parameter int     SHORT_CYC   = 8,
  parameter longint POR_DIP_CYC = 20
) (
  // Clock, reset, enable
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic       ce,
  // Register port
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata_q,
  // Comparators, straps, watchdog
  input wire logic       supply_dip_below,
  input wire logic       analog_supply_low,
  input wire logic       hw_config_first_wdog_en,
  input wire logic       wdog_timeout,
  // Outputs under watch
  input wire logic       sys_rst_q,
  input wire logic       pins_pull_high_q,
  input wire logic       osc_halt_q,
  input wire logic       lvd_irq_analog_q,
  input wire logic       lvd_irq_digital_q,
  input wire logic [7:0] low_voltage_detect_control_q
);
  import rss_pkg::*;
  logic [7:0] hi_q, sw_age_q;
  logic       sw_q, wd_q;
  wire sw_go  = ce && sfr_wr && sfr_addr == RSS_SWRST_ADDR && sfr_wdata[RSS_SWRST_TRIG_BIT];
  wire lvd_wr = ce && sfr_wr && sfr_addr == RSS_LVD_ADDR;
  wire lvd_rd = ce && sfr_rd && !sfr_wr && sfr_addr == RSS_LVD_ADDR;
  // Watchdog shadow cleared by any reset, so it can only under-report
  always_ff @(posedge mclk) begin
    // Counters start from zero in reset so no unknown reaches a compare
    hi_q     <= (!rst_n || !sys_rst_q) ? 8'h00 : hi_q + {7'h00, ce && hi_q != 8'hFF};
    sw_age_q <= (!rst_n || sw_go) ? 8'h00 : sw_age_q + {7'h00, ce && sw_age_q != 8'hFF};
    sw_q     <= (!rst_n || supply_dip_below) ? 1'h0 : (sw_go || (sw_q && sys_rst_q));
    wd_q     <= (!rst_n || sys_rst_q) ? 1'h0 :
                (ce && sfr_wr && sfr_addr == RSS_WDOG_ADDR) ? sfr_wdata[RSS_WDOG_EN_BIT] : wd_q;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_sw_go;
    sw_go;
  endsequence
  sequence s_wd_go;
    ce && wdog_timeout && hw_config_first_wdog_en && wd_q;
  endsequence
  a_pins_follow: assert property (pins_pull_high_q == sys_rst_q)
    else $error("pins not following reset");
  a_sw_starts: assert property (s_sw_go |=> sys_rst_q)
    else $error("software write did not start reset");
  a_wdog_starts: assert property (s_wd_go |=> sys_rst_q)
    else $error("watchdog timeout did not start reset");
  a_halt_in_rst: assert property (osc_halt_q |-> sys_rst_q)
    else $error("halt without reset");
  a_pin_fall_count: assert property ($fell(osc_halt_q) |-> sys_rst_q [*8])
    else $error("reset ended early after pin fall");
  a_min_stretch: assert property ($fell(sys_rst_q) |-> $past(hi_q) >= SHORT_CYC - 1)
    else $error("reset shorter than short stretch");
  a_sw_stretch: assert property ($fell(sys_rst_q) && $past(sw_q) |->
    $past(sw_age_q) >= LONG_CYC - 2) else $error("software reset too short");
  a_irq_single: assert property (lvd_irq_analog_q |=> !lvd_irq_analog_q)
    else $error("analog flag longer than one cycle");
  a_irq_single_dig: assert property (lvd_irq_digital_q |=> !lvd_irq_digital_q)
    else $error("digital flag longer than one cycle");
  a_irq_follows: assert property ($rose(analog_supply_low) |->
    ##[1:6] (lvd_irq_analog_q || !analog_supply_low)) else $error("analog flag missing");
  a_lvd_write: assert property (lvd_wr |=>
    low_voltage_detect_control_q == $past(sfr_wdata))
    else $error("threshold register not written");
  a_lvd_read: assert property (lvd_rd |=>
    sfr_rdata_q == $past(low_voltage_detect_control_q))
    else $error("threshold register read mismatch");
endmodule : rss_seq_properties
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the reset source sequencer.
// Assumes rss_rails stands in for the reset pin and the supply rails.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import rss_pkg::*;
  localparam int LC = 16;
  localparam int SC = 8;
  logic       mclk = 1'h0, rst_n = 1'h0, ce = 1'h1, sfr_wr = 1'h0, sfr_rd = 1'h0;
  logic       hw_config_first_wdog_en = 1'h0, hw_config_second_dip_en = 1'h0;
  logic       wdog_timeout = 1'h0, sys_rst_q, pins_pull_high_q, osc_halt_q;
  logic       lvd_irq_analog_q, lvd_irq_digital_q;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata_q, low_voltage_detect_control_q, d;
  logic [5:0] lvl;
  logic [7:0] ra [4] = '{RSS_LVD_ADDR, RSS_SWRST_ADDR, RSS_WDOG_ADDR, 8'h10};
  logic [7:0] ex [4] = '{8'hA4, 8'hA4, 8'hA4, 8'h00};
  int         num_errors = 0, samples_checked = 0, n;
  always #10 mclk = ~mclk;
  rss_rails rss_rails_i (.mclk(mclk), .lvl(lvl));
  rss_sequencer #(.LONG_CYC(LC), .SHORT_CYC(SC), .POR_DIP_CYC(20)) rss_sequencer_i (
    .ext_rst_pin(lvl[RSS_IX_EXT]), .digital_supply_below_1v(lvl[RSS_IX_LOW1V]),
    .digital_supply_above_2v(lvl[RSS_IX_ABOVE2V]), .supply_dip_below(lvl[RSS_IX_DIP]),
    .analog_supply_low(lvl[RSS_IX_ALVD]), .digital_supply_low(lvl[RSS_IX_DLVD]), .*);
  task automatic give_verdict;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic chk_len(input string nm, input int lo, input int hi);
    samples_checked++;
    if (n < lo || n > hi) begin
      num_errors++;
      $display("[FAIL] %s exp %0d..%0d got %0d", nm, lo, hi, n);
    end
  endtask : chk_len
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    sfr_addr  <= a;
    sfr_wdata <= v;
    sfr_wr    <= 1'h1;
    @(posedge mclk);
    sfr_wr <= 1'h0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    sfr_addr <= a;
    sfr_rd   <= 1'h1;
    @(posedge mclk);
    sfr_rd <= 1'h0;
    #1 d = sfr_rdata_q;
  endtask : rd
  task automatic pulse_wd(input logic en);
    @(posedge mclk);
    hw_config_first_wdog_en <= en;
    wdog_timeout <= 1'h1;
    @(posedge mclk);
    wdog_timeout <= 1'h0;
    #1;
  endtask : pulse_wd
  // Bounded wait for reset to finish, counting its cycles
  task automatic len;
    n = 0;
    while (sys_rst_q === 1'h1 && n < 500) begin
      @(posedge mclk);
      #1 n++;
    end
    if (n >= 500) begin
      num_errors++;
      give_verdict();
    end
  endtask : len
  task automatic stays_low(input string nm);
    repeat (6) @(posedge mclk);
    #1 chk(nm, 8'h00, {7'h00, sys_rst_q});
  endtask : stays_low
  initial begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'h1;
    repeat (10) @(posedge mclk);
    #1 chk("por hold", 8'h01, {7'h00, sys_rst_q});
    rss_rails_i.flip(6'h04);
    len(); chk_len("por len", LC + 2, LC + 6);
    foreach (ra[i]) begin
      rd(ra[i]); chk("reg reset", 8'h00, d);
      wr(ra[i], 8'hA4);
      rd(ra[i]); chk("reg rw", ex[i], d);
    end
    chk("lvd out", 8'hA4, low_voltage_detect_control_q);
    pulse_wd(1'h0);
    stays_low("wd gated");
    pulse_wd(1'h1); chk("wd rst", 8'h01, {7'h00, sys_rst_q});
    len(); chk_len("wd len", LC - 1, LC + 2);
    wr(RSS_SWRST_ADDR, 8'h01); chk("sw pins", 8'h01, {7'h00, pins_pull_high_q});
    repeat (4) @(posedge mclk);
    wr(RSS_SWRST_ADDR, 8'h01);
    len(); chk_len("sw len", LC - 1, LC + 2);
    rd(RSS_SWRST_ADDR); chk("sw clear", 8'h00, d);
    rss_rails_i.pulse(6'h01, 10);
    #1 chk("halt", 8'h01, {7'h00, osc_halt_q});
    len(); chk_len("pin len", LC + 2, LC + 6);
    rss_rails_i.pulse(6'h08, 10);
    stays_low("dip off");
    @(posedge mclk);
    hw_config_second_dip_en <= 1'h1;
    rss_rails_i.pulse(6'h08, 10);
    #1 chk("dip hold", 8'h01, {7'h00, sys_rst_q});
    len(); chk_len("dip len", SC + 2, SC + 6);
    rss_rails_i.pulse(6'h06, 30);
    stays_low("por masked");
    @(posedge mclk);
    hw_config_second_dip_en <= 1'h0;
    rss_rails_i.pulse(6'h06, 10);
    stays_low("short dip");
    rss_rails_i.pulse(6'h06, 30);
    #1 chk("por again", 8'h01, {7'h00, sys_rst_q});
    // Rearm still wins for one cycle as the dip timer clears
    len(); chk_len("por2 len", LC + 3, LC + 7);
    for (int k = 0; k < 2; k++) begin
      rss_rails_i.flip(6'h10 << k);
      d = 8'h00;
      repeat (10) begin
        @(posedge mclk);
        #1 d += {7'h00, k ? lvd_irq_digital_q : lvd_irq_analog_q};
      end
      rss_rails_i.flip(6'h10 << k);
      chk("lvd irq", 8'h01, d);
    end
    give_verdict();
  end
endmodule : tb
bind rss_sequencer rss_seq_properties #(.LONG_CYC(LONG_CYC), .SHORT_CYC(SHORT_CYC),
  .POR_DIP_CYC(POR_DIP_CYC)) rss_seq_properties_i (.*);
`default_nettype wire
